// >>> scp_pkg.sv
// scp_pkg: constants, states and helpers of the serial configuration port
// assumes: one 250 MHz core clock drives every module that imports it
package scp_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int EE_SCL_HZ = 100_000;
  // quarter of an eeprom clock period, rounded down
  localparam int EE_QTR_CYC = CLK_HZ / (4 * EE_SCL_HZ);
  localparam int EE_QTR_W = 10;
  localparam logic [6:0] EE_DEV_ADDR = 7'h50;
  localparam logic [4:0] I2C_ADDR_HI = 5'h1C;
  localparam logic [3:0] STEP_LAST = 4'h8;
  // register addresses
  localparam logic [7:0] A_GPIO_DIR = 8'h00;
  localparam logic [7:0] A_GPIO_FUNC = 8'h01;
  localparam logic [7:0] A_GPIO_OUT = 8'h02;
  localparam logic [7:0] A_PLL0_BW = 8'h03;
  localparam logic [7:0] A_PLL1_BW = 8'h04;
  localparam logic [7:0] A_INT_MASK = 8'h05;
  localparam logic [7:0] A_INT_FLAG = 8'h06;
  localparam logic [7:0] A_GPIO_IN = 8'h07;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam int CFG_N = 6;
  // reset values
  localparam logic [7:0] RST_GPIO_OUT = 8'hFF;
  localparam logic [7:0] RST_PLL_BW = 8'h05;
  localparam logic [7:0] BW_MAX = 8'h0A;
  // positions in the synchronised pin vector
  localparam int SY_MODE = 0;
  localparam int SY_MRST = 1;
  localparam int SY_WP = 2;
  localparam int SY_ALO = 3;
  localparam int SY_AHI = 4;
  localparam int SY_SDA = 5;
  localparam int SY_SCL = 6;
  localparam int SY_GPIO = 7;
  localparam int SY_W = 15;

  typedef enum logic [2:0] {HS_IDLE = 3'h0, HS_DEV = 3'h1, HS_REG = 3'h3, HS_WR = 3'h2,
                            HS_RD = 3'h6} scp_hs_e;
  typedef enum logic [2:0] {LD_IDLE = 3'h0, LD_START = 3'h1, LD_BIT = 3'h3,
                            LD_STOP = 3'h2} scp_ld_e;

  function automatic logic [7:0] scp_cfg_rst(input int i);
    if (i == int'(A_GPIO_OUT))
      return RST_GPIO_OUT;
    if (i == int'(A_PLL0_BW) || i == int'(A_PLL1_BW))
      return RST_PLL_BW;
    return 8'h00;
  endfunction : scp_cfg_rst

  // bandwidth fields saturate at the highest of the eleven steps
  function automatic logic [7:0] scp_wr_val(input logic [7:0] a, input logic [7:0] d);
    if ((a == A_PLL0_BW || a == A_PLL1_BW) && d > BW_MAX)
      return BW_MAX;
    return d;
  endfunction : scp_wr_val
endpackage : scp_pkg

// >>> scp_load_if.sv
// scp_load_if: eeprom loader handshake and its share of the two-wire pins
// assumes: bank and loader sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface scp_load_if;
  logic go, clr, busy, wr, sda_in, scl_low, sda_low;
  logic [2:0] idx;
  logic [7:0] data;
  modport loader(input go, clr, sda_in, output busy, wr, idx, data, scl_low, sda_low);
  modport bank(output go, clr, sda_in, input busy, wr, idx, data, scl_low, sda_low);
endinterface : scp_load_if
`default_nettype wire

// >>> scp_eeprom_loader.sv
// scp_eeprom_loader: two-wire master that reads the configuration bytes
// assumes: sda_in is already synchronised; pin drive is muxed by the bank
`timescale 1ns/1ps
`default_nettype none
module scp_eeprom_loader (
  input wire logic clk,
  input wire logic rst,
  scp_load_if.loader ld
);
  import scp_pkg::*;
  scp_ld_e st_r, st_nxt;
  logic [EE_QTR_W-1:0] div_r, div_nxt;
  logic [1:0] q_r, q_nxt;
  logic [3:0] bit_r, bit_nxt, step_r, step_nxt;
  logic [7:0] sh_r, sh_nxt, tx;
  logic [2:0] idx_r, idx_nxt;
  logic scl_r, scl_nxt, sda_r, sda_nxt, wr_r, wr_nxt, tick, rd_step;

  assign ld.busy = (st_r != LD_IDLE);
  assign ld.wr = wr_r;
  assign ld.idx = idx_r;
  assign ld.data = sh_r;
  assign ld.scl_low = scl_r;
  assign ld.sda_low = sda_r;
  assign tick = (div_r == EE_QTR_W'(EE_QTR_CYC - 1));
  // steps: 0 device write, 1 word address, 2 device read, 3.. data bytes
  assign rd_step = (step_r > 4'h2);
  assign tx = (step_r == 4'h0) ? {EE_DEV_ADDR, 1'b0} :
              (step_r == 4'h2) ? {EE_DEV_ADDR, 1'b1} : (step_r == 4'h1) ? 8'h00 : 8'hFF;

  // quarter-period sequencer; scl_r and sda_r mean "pull the line low"
  always_comb
  begin
    st_nxt = st_r;
    div_nxt = (st_r == LD_IDLE || tick) ? '0 : div_r + 1'b1;
    q_nxt = q_r;
    bit_nxt = bit_r;
    step_nxt = step_r;
    sh_nxt = sh_r;
    idx_nxt = idx_r;
    scl_nxt = scl_r;
    sda_nxt = sda_r;
    wr_nxt = 1'b0;
    if (ld.clr)
    begin
      st_nxt = LD_IDLE;
      q_nxt = 2'h0;
      scl_nxt = 1'b0;
      sda_nxt = 1'b0;
    end
    else if (st_r == LD_IDLE)
    begin
      if (ld.go)
      begin
        st_nxt = LD_START;
        step_nxt = 4'h0;
        q_nxt = 2'h0;
      end
    end
    else if (tick)
    begin
      q_nxt = q_r + 2'h1;
      unique case (st_r)
        LD_START:
          unique case (q_r)
            2'h0: {scl_nxt, sda_nxt} = 2'h0;
            2'h1: sda_nxt = 1'b1;
            2'h2: scl_nxt = 1'b1;
            2'h3:
            begin
              bit_nxt = 4'h0;
              st_nxt = LD_BIT; // start is on the bus, first address bit next
            end
          endcase
        LD_BIT:
          unique case (q_r)
            2'h0: sda_nxt = (bit_r == 4'h8) ? (rd_step && step_r != STEP_LAST)
                                            : ~tx[3'h7 - bit_r[2:0]];
            2'h1: scl_nxt = 1'b0;
            2'h2:
              if (bit_r != 4'h8)
                sh_nxt = {sh_r[6:0], ld.sda_in};
              else if (!rd_step && ld.sda_in)
              begin
                st_nxt = LD_STOP; // no acknowledge: give the bus back
                q_nxt = 2'h0;
              end
            2'h3:
            begin
              scl_nxt = 1'b1;
              bit_nxt = bit_r + 4'h1;
              if (bit_r == 4'h8)
              begin
                bit_nxt = 4'h0;
                step_nxt = step_r + 4'h1;
                wr_nxt = rd_step;
                idx_nxt = 3'(step_r - 4'h3);
                if (step_r == 4'h1)
                  st_nxt = LD_START;
                else if (step_r == STEP_LAST)
                  st_nxt = LD_STOP;
              end
            end
          endcase
        LD_STOP:
          unique case (q_r)
            2'h0: {scl_nxt, sda_nxt} = 2'h3;
            2'h1: scl_nxt = 1'b0;
            2'h2: sda_nxt = 1'b0;
            2'h3: st_nxt = LD_IDLE;
          endcase
        default: st_nxt = LD_IDLE;
      endcase
    end
  end

  // loader state registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= LD_IDLE;
      div_r <= '0;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      step_r <= 4'h0;
      sh_r <= 8'h00;
      idx_r <= 3'h0;
      scl_r <= 1'b0;
      sda_r <= 1'b0;
      wr_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      q_r <= q_nxt;
      bit_r <= bit_nxt;
      step_r <= step_nxt;
      sh_r <= sh_nxt;
      idx_r <= idx_nxt;
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
      wr_r <= wr_nxt;
    end
  end

  go_start_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == LD_IDLE && ld.go && !ld.clr) |=> (st_r == LD_START && !scl_r))
    else $error("eeprom read did not start");
endmodule : scp_eeprom_loader
`default_nettype wire

// >>> scp_port_ctrl.sv
// scp_port_ctrl: host serial port (two-wire or spi), register bank, gpio
// and eeprom boot load of a clock translator
// assumes: pins arrive asynchronous; status inputs are on CLK
`timescale 1ns/1ps
`default_nettype none
module scp_port_ctrl (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic HOST_PROTOCOL_SELECT,
  input wire logic MASTER_RESET_N,
  input wire logic WRITE_PROTECT_N,
  input wire logic SLAVE_ADDR_BIT_LOW,
  input wire logic SLAVE_ADDR_BIT_HIGH,
  input wire logic TWO_WIRE_DATA_LINE_I,
  output logic TWO_WIRE_DATA_LINE_O,
  output logic TWO_WIRE_DATA_LINE_OE_N,
  input wire logic SER_CLK_I,
  output logic SER_CLK_O,
  output logic SER_CLK_OE_N,
  input wire logic [7:0] GPIO_I,
  output logic [7:0] GPIO_O,
  output logic [7:0] GPIO_OE_N,
  output logic IRQ_OUT_N_O,
  output logic IRQ_OUT_N_OE_N,
  input wire logic [1:0] LOCK_IN,
  input wire logic [1:0] HOLDOVER_IN,
  input wire logic [3:0] SIGNAL_LOSS_FLAG,
  output logic [7:0] OUT_ENABLE,
  output logic [3:0] PLL0_BW_SEL,
  output logic [3:0] PLL1_BW_SEL,
  output logic EEPROM_BUSY
);
  import scp_pkg::*;
  logic [SY_W-1:0] raw, s1_r, s2_r, s3_r, flt_r, flt_nxt, prv_r;
  logic spi_mode, sres, wp_on, scl, sda, cs_n, din, scl_rise, scl_fall, h_start, h_stop;
  scp_hs_e hs_r, hs_nxt;
  logic [3:0] hbit_r, hbit_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, byte_in, rdata;
  logic ack_r, ack_nxt, drv_r, drv_nxt, hw;
  logic [7:0] cfg_r [CFG_N];
  logic [7:0] cfg_nxt [CFG_N];
  logic [7:0] flag_r, flag_nxt, stat, stat_prv_r, dir, func, gout, mask;
  logic boot_r, boot_nxt, go_r, go_nxt;
  logic d_o_r, d_o_nxt, d_oe_n_r, d_oe_n_nxt, c_oe_n_r, c_oe_n_nxt, irq_r, irq_nxt, busy_r;
  logic [7:0] gpio_oe_n_r, gpio_oe_n_nxt, oe_r, oe_nxt;
  scp_load_if ld ();

  scp_eeprom_loader u_loader (
    .clk(CLK),
    .rst(SYS_RST),
    .ld(ld.loader)
  );

  // pin levels: three stages, a change counts once stages two and three agree
  assign raw = {GPIO_I, SER_CLK_I, TWO_WIRE_DATA_LINE_I, SLAVE_ADDR_BIT_HIGH,
                SLAVE_ADDR_BIT_LOW, WRITE_PROTECT_N, MASTER_RESET_N, HOST_PROTOCOL_SELECT};
  assign flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      {s1_r, s2_r, s3_r, flt_r, prv_r} <= '0;
    else
      {s1_r, s2_r, s3_r, flt_r, prv_r} <= {raw, s1_r, s2_r, flt_nxt, flt_r};
  end

  // pin roles and bus events
  assign spi_mode = flt_r[SY_MODE];
  assign sres = ~flt_r[SY_MRST];
  assign wp_on = ~flt_r[SY_WP];
  assign scl = flt_r[SY_SCL];
  assign sda = flt_r[SY_SDA];
  assign cs_n = flt_r[SY_ALO];
  assign din = spi_mode ? flt_r[SY_AHI] : sda;
  assign scl_rise = scl & ~prv_r[SY_SCL];
  assign scl_fall = ~scl & prv_r[SY_SCL];
  assign h_start = spi_mode ? (~cs_n & prv_r[SY_ALO]) : (scl & prv_r[SY_SCL] & ~sda & prv_r[SY_SDA]);
  assign h_stop = spi_mode ? (cs_n & ~prv_r[SY_ALO]) : (scl & prv_r[SY_SCL] & sda & ~prv_r[SY_SDA]);
  assign byte_in = {sh_r[6:0], din};
  assign stat = {SIGNAL_LOSS_FLAG, HOLDOVER_IN, LOCK_IN};
  assign dir = cfg_r[A_GPIO_DIR[2:0]];
  assign func = cfg_r[A_GPIO_FUNC[2:0]];
  assign gout = cfg_r[A_GPIO_OUT[2:0]];
  assign mask = cfg_r[A_INT_MASK[2:0]];
  assign ld.go = go_r;
  assign ld.clr = sres;
  assign ld.sda_in = sda;

  // read data at the pointer; unmapped addresses read zero
  always_comb
  begin
    rdata = 8'h00;
    if (ptr_r < 8'(CFG_N))
      rdata = cfg_r[ptr_r[2:0]];
    else if (ptr_r == A_INT_FLAG)
      rdata = flag_r;
    else if (ptr_r == A_GPIO_IN)
      rdata = flt_r[SY_GPIO +: 8];
    else if (ptr_r == A_STATUS)
      rdata = stat;
  end

  // host port engine; data moves on clock rise, output changes on fall
  always_comb
  begin
    hs_nxt = hs_r;
    hbit_nxt = hbit_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    ack_nxt = ack_r;
    drv_nxt = drv_r;
    hw = 1'b0;
    if (sres || ld.busy || h_stop)
    begin
      hs_nxt = HS_IDLE;
      ack_nxt = 1'b0;
      drv_nxt = 1'b0;
    end
    else if (h_start)
    begin
      hs_nxt = spi_mode ? HS_REG : HS_DEV;
      hbit_nxt = 4'h0;
      ack_nxt = 1'b0;
      drv_nxt = 1'b0;
    end
    else if (hs_r != HS_IDLE && scl_rise)
    begin
      if (hbit_r == 4'h8)
      begin
        hbit_nxt = 4'h0;
        ack_nxt = 1'b0;
        if (hs_r == HS_RD && sda)
          hs_nxt = HS_IDLE; // master declined further read data
      end
      else
      begin
        sh_nxt = byte_in;
        hbit_nxt = hbit_r + 4'h1;
        if (hbit_r == 4'h7)
        begin
          hbit_nxt = spi_mode ? 4'h0 : 4'h8;
          ack_nxt = ~spi_mode;
          unique case (hs_r)
            HS_DEV:
              if (byte_in[7:1] == {I2C_ADDR_HI, flt_r[SY_AHI], flt_r[SY_ALO]})
                hs_nxt = byte_in[0] ? HS_RD : HS_REG;
              else
              begin
                hs_nxt = HS_IDLE;
                ack_nxt = 1'b0;
              end
            HS_REG:
            begin
              ptr_nxt = spi_mode ? {1'b0, byte_in[6:0]} : byte_in;
              hs_nxt = (spi_mode && byte_in[7]) ? HS_RD : HS_WR;
            end
            HS_WR:
            begin
              hw = 1'b1; // the transfer itself always completes
              ptr_nxt = ptr_r + 8'h01;
            end
            default:
            begin
              ptr_nxt = ptr_r + 8'h01;
              ack_nxt = 1'b0;
            end
          endcase
        end
      end
    end
    else if (hs_r != HS_IDLE && scl_fall)
    begin
      if (spi_mode)
        drv_nxt = (hs_r == HS_RD) && rdata[3'h7 - hbit_r[2:0]];
      else if (hbit_r == 4'h8)
        drv_nxt = ack_r;
      else
        drv_nxt = (hs_r == HS_RD) && !rdata[3'h7 - hbit_r[2:0]];
    end
  end

  // register bank; a new event outweighs a clear in the same cycle
  always_comb
  begin
    cfg_nxt = cfg_r;
    flag_nxt = flag_r;
    if (hw && ptr_r == A_INT_FLAG)
      flag_nxt = flag_r & ~byte_in;
    flag_nxt = flag_nxt | (stat & ~stat_prv_r);
    if (hw && ptr_r < 8'(CFG_N) && (!wp_on || ptr_r == A_INT_MASK))
      cfg_nxt[ptr_r[2:0]] = scp_wr_val(ptr_r, byte_in);
    if (ld.wr)
      cfg_nxt[ld.idx] = scp_wr_val({5'h00, ld.idx}, ld.data);
    boot_nxt = ~sres;
    go_nxt = ~sres & ~boot_r & ~spi_mode;
    if (sres)
    begin
      for (int i = 0; i < CFG_N; i++)
        cfg_nxt[i] = scp_cfg_rst(i);
      flag_nxt = 8'h00;
    end
  end

  // registered pin drive; the loader owns the two-wire pins while it runs
  always_comb
  begin
    d_o_nxt = spi_mode & drv_r;
    d_oe_n_nxt = spi_mode ? cs_n : ~drv_r;
    c_oe_n_nxt = 1'b1; // the clock is only ever an input to the slave
    if (ld.busy)
    begin
      d_o_nxt = 1'b0;
      d_oe_n_nxt = ~ld.sda_low;
      c_oe_n_nxt = ~ld.scl_low;
    end
    // open drain: an output bit of one is left to the pull-up
    gpio_oe_n_nxt = ~(dir & ~((func & stat) | (~func & gout)));
    oe_nxt = ~(func & ~dir) | flt_r[SY_GPIO +: 8];
    irq_nxt = ~|(flag_r & mask);
  end

  // state and output registers
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      hs_r <= HS_IDLE;
      hbit_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      ack_r <= 1'b0;
      drv_r <= 1'b0;
      for (int i = 0; i < CFG_N; i++)
        cfg_r[i] <= scp_cfg_rst(i);
      flag_r <= 8'h00;
      stat_prv_r <= 8'h00;
      boot_r <= 1'b0;
      go_r <= 1'b0;
      d_o_r <= 1'b0;
      d_oe_n_r <= 1'b1;
      c_oe_n_r <= 1'b1;
      irq_r <= 1'b1;
      gpio_oe_n_r <= 8'hFF;
      oe_r <= 8'hFF;
      busy_r <= 1'b0;
    end
    else
    begin
      hs_r <= hs_nxt;
      hbit_r <= hbit_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      ack_r <= ack_nxt;
      drv_r <= drv_nxt;
      cfg_r <= cfg_nxt;
      flag_r <= flag_nxt;
      stat_prv_r <= stat;
      boot_r <= boot_nxt;
      go_r <= go_nxt;
      d_o_r <= d_o_nxt;
      d_oe_n_r <= d_oe_n_nxt;
      c_oe_n_r <= c_oe_n_nxt;
      irq_r <= irq_nxt;
      gpio_oe_n_r <= gpio_oe_n_nxt;
      oe_r <= oe_nxt;
      busy_r <= ld.busy;
    end
  end

  assign TWO_WIRE_DATA_LINE_O = d_o_r;
  assign TWO_WIRE_DATA_LINE_OE_N = d_oe_n_r;
  assign SER_CLK_O = 1'b0;
  assign SER_CLK_OE_N = c_oe_n_r;
  assign GPIO_O = 8'h00;
  assign GPIO_OE_N = gpio_oe_n_r;
  assign IRQ_OUT_N_O = 1'b0;
  assign IRQ_OUT_N_OE_N = irq_r;
  assign OUT_ENABLE = oe_r;
  assign PLL0_BW_SEL = cfg_r[A_PLL0_BW[2:0]][3:0];
  assign PLL1_BW_SEL = cfg_r[A_PLL1_BW[2:0]][3:0];
  assign EEPROM_BUSY = busy_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence spi_sel_s; spi_mode && h_start && !sres && !ld.busy; endsequence
  sequence cmd_phase_s; hs_r == HS_REG && hbit_r == 4'h0; endsequence
  spi_cmd_a: assert property (spi_sel_s |=> cmd_phase_s)
    else $error("spi select did not open a command");
  wp_hold_a: assert property ((hw && wp_on && ptr_r == A_GPIO_DIR && !sres) |=> $stable(dir))
    else $error("protected register changed");
  wp_open_a: assert property ((hw && !wp_on && ptr_r == A_GPIO_OUT && !sres && !ld.wr)
    |=> gout == $past(byte_in)) else $error("unprotected write lost");
  bw_range_a: assert property (PLL0_BW_SEL <= BW_MAX[3:0] && PLL1_BW_SEL <= BW_MAX[3:0])
    else $error("bandwidth step out of range");
  soft_rst_a: assert property (sres |=> (flag_r == 8'h00 && gout == RST_GPIO_OUT))
    else $error("master reset left state");
  no_spi_load_a: assert property (go_r |-> !spi_mode)
    else $error("eeprom load in spi mode");
  irq_pull_a: assert property ((|(flag_r & mask)) |=> !IRQ_OUT_N_OE_N)
    else $error("interrupt not asserted");
  sdo_hiz_a: assert property ((spi_mode && cs_n && !ld.busy) |=> TWO_WIRE_DATA_LINE_OE_N)
    else $error("data out driven while deselected");
  oe_gate_a: assert property ((func == 8'hFF && dir == 8'h00)
    |=> OUT_ENABLE == $past(flt_r[SY_GPIO +: 8])) else $error("enable input not followed");
  gpio_stat_a: assert property ((func == 8'hFF && dir == 8'hFF)
    |=> GPIO_OE_N == $past(stat)) else $error("status not shown on gpio");
endmodule : scp_port_ctrl
`default_nettype wire

// >>> scp_host_model.sv
// scp_host_model: spi and two-wire host that drives the shared port pins
// assumes: the bench resolves the data pin pull-up and calls xfer
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
  input wire logic clk,
  input wire logic port_serial_out,
  output logic sel_n,
  output logic port_serial_in,
  output logic sck,
  output logic sda_pull,
  output logic scl_pull
);
  localparam int HALF = 10; // stays above the pin filter lag
  // idle: deselected, clock low for mode 0
  initial
  begin
    sel_n = 1'b1;
    port_serial_in = 1'b0;
    sck = 1'b0;
    sda_pull = 1'b0;
    scl_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // command byte then one data byte, msb first, sampled on clock rise
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] q);
    logic [15:0] sh;
    sh = {rd, a, wd};
    q = 8'h00;
    sel_n <= 1'b0;
    tick(HALF);
    for (int i = 15; i >= 0; i--)
    begin
      port_serial_in <= sh[i];
      tick(HALF);
      sck <= 1'b1;
      tick(1);
      if (i < 8)
        q = {q[6:0], port_serial_out};
      tick(HALF - 1);
      sck <= 1'b0;
    end
    tick(HALF);
    sel_n <= 1'b1;
    port_serial_in <= ~port_serial_in; // no stale level once deselected
    tick(HALF);
  endtask : xfer
  // two-wire bit: data moves while the clock is low, the level is read while it is high
  task automatic tw_bit(input logic b, output logic s);
    tick(HALF);
    sda_pull <= ~b;
    tick(HALF);
    scl_pull <= 1'b0;
    tick(HALF);
    s = port_serial_out;
    scl_pull <= 1'b1;
  endtask : tw_bit
  // eight bits msb first, then the ninth; the ninth level comes back as ack
  task automatic tw_byte(input logic [7:0] b, input logic mack, output logic [7:0] q,
                         output logic ack);
    logic s;
    q = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      tw_bit(b[i], s);
      q = {q[6:0], s};
    end
    tw_bit(mack, ack);
  endtask : tw_byte
  // start or repeated start: data falls while the clock is high
  task automatic tw_start;
    tick(HALF);
    sda_pull <= 1'b0;
    tick(HALF);
    scl_pull <= 1'b0;
    tick(HALF);
    sda_pull <= 1'b1;
    tick(HALF);
    scl_pull <= 1'b1;
  endtask : tw_start
  // stop: data rises while the clock is high
  task automatic tw_stop;
    tick(HALF);
    sda_pull <= 1'b1;
    tick(HALF);
    scl_pull <= 1'b0;
    tick(HALF);
    sda_pull <= 1'b0;
    tick(HALF);
  endtask : tw_stop
  // write: address, register, data; read: address, register, restart, address, data
  task automatic tw_xfer(input logic rd, input logic [6:0] dev, input logic [7:0] a,
                         input logic [7:0] wd, output logic [7:0] q, output logic [2:0] acks);
    logic [7:0] x;
    q = 8'h00;
    sel_n <= dev[0];
    port_serial_in <= dev[1];
    tw_start();
    tw_byte({dev, 1'b0}, 1'b1, x, acks[2]);
    tw_byte(a, 1'b1, x, acks[1]);
    if (rd)
    begin
      tw_start();
      tw_byte({dev, 1'b1}, 1'b1, x, acks[0]);
      tw_byte(8'hFF, 1'b1, q, x[0]); // host declines further data
    end
    else
      tw_byte(wd, 1'b1, x, acks[0]);
    tw_stop();
  endtask : tw_xfer
endmodule : scp_host_model
`default_nettype wire

// >>> serial_config_port_control_tb_top.sv
// serial_config_port_control_tb_top: self-checking bench of scp_port_ctrl
// assumes: pull-ups on the open-drain pins are resolved here
`timescale 1ns/1ps
`default_nettype none
module serial_config_port_control_tb_top;
  import scp_pkg::*;
  logic clk, rst, mode, mrst_n, wp_n, sel_n, port_serial_in, sck, sda_i, scl_i;
  logic sda_o, sda_oe_n, irq_oe_n, busy, scl_oe_n, sda_pull, scl_pull, saw_scl;
  logic [7:0] gdrv, gpio_i, gpio_oe_n, oe, rd, st, e_oen, wd;
  logic [6:0] a7;
  logic [2:0] acks;
  logic [1:0] lock, hold;
  logic [3:0] signal_loss_flag, bw0, bw1;
  int fails, num_checks, seed;
  int mdl [0:8];
  // open-drain pins read low wherever someone pulls
  assign sda_i = (sda_oe_n ? 1'b1 : sda_o) & ~sda_pull;
  assign scl_i = (mode ? sck : ~scl_pull) & scl_oe_n;
  assign gpio_i = gdrv & gpio_oe_n;
  scp_port_ctrl i_dut (.CLK(clk), .SYS_RST(rst), .HOST_PROTOCOL_SELECT(mode),
    .MASTER_RESET_N(mrst_n), .WRITE_PROTECT_N(wp_n), .SLAVE_ADDR_BIT_LOW(sel_n),
    .SLAVE_ADDR_BIT_HIGH(port_serial_in), .TWO_WIRE_DATA_LINE_I(sda_i),
    .TWO_WIRE_DATA_LINE_O(sda_o), .TWO_WIRE_DATA_LINE_OE_N(sda_oe_n),
    .SER_CLK_I(scl_i), .SER_CLK_O(), .SER_CLK_OE_N(scl_oe_n), .GPIO_I(gpio_i), .GPIO_O(),
    .GPIO_OE_N(gpio_oe_n), .IRQ_OUT_N_O(), .IRQ_OUT_N_OE_N(irq_oe_n), .LOCK_IN(lock),
    .HOLDOVER_IN(hold), .SIGNAL_LOSS_FLAG(signal_loss_flag), .OUT_ENABLE(oe), .PLL0_BW_SEL(bw0),
    .PLL1_BW_SEL(bw1), .EEPROM_BUSY(busy));
  scp_host_model i_host (.clk(clk), .port_serial_out(sda_i), .sel_n(sel_n), .port_serial_in(port_serial_in), .sck(sck),
    .sda_pull(sda_pull), .scl_pull(scl_pull));
  // remembers whether the loader ever pulled the clock pin low
  always @(posedge clk)
  begin
    if (rst)
      saw_scl <= 1'b0;
    else if (scl_oe_n === 1'b0)
      saw_scl <= 1'b1;
  end
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  // model of the register bank after a reset
  task automatic mdl_rst;
    foreach (mdl[i])
      mdl[i] = 0;
    mdl[2] = 8'hFF;
    mdl[3] = 5;
    mdl[4] = 5;
  endtask : mdl_rst
  // write through the port; the model keeps protect, saturation and clear
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [7:0] x;
    i_host.xfer(1'b0, a[6:0], d, x);
    if (a == 8'h06)
      mdl[6] = mdl[6] & ~int'(d);
    else if ((wp_n || a == 8'h05) && a < 8'h06)
      mdl[a] = (a == 8'h03 || a == 8'h04) && d > 8'h0A ? 10 : int'(d);
  endtask : wr
  task automatic rd8(logic [7:0] a);
    i_host.xfer(1'b1, a[6:0], 8'h00, rd);
  endtask : rd8
  task automatic wait_busy(logic lvl, int n);
    while (busy !== lvl && n > 0)
    begin
      @(posedge clk);
      n--;
    end
    check("EEPROM_BUSY", {7'h00, busy}, {7'h00, lvl});
    if (busy !== lvl)
      finish_test();
  endtask : wait_busy
  initial
  begin
    seed = 32'h41be;
    rst = 1'b1;
    mode = 1'b1;
    mrst_n = 1'b1;
    wp_n = 1'b1;
    gdrv = 8'hFF;
    lock = 2'h0;
    hold = 2'h0;
    signal_loss_flag = 4'h0;
    mdl_rst();
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    check("OUT_ENABLE", oe, 8'hFF);
    check("GPIO_OE_N", gpio_oe_n, 8'hFF);
    check("IRQ_OE_N", {7'h00, irq_oe_n}, 8'h01);
    check("EEPROM_BUSY", {7'h00, busy}, 8'h00);
    $display("test reset done");
    // every bandwidth step, the last pass is out of range
    for (int s = 0; s < 12; s++)
    begin
      wr(A_PLL0_BW, 8'(s));
      wr(A_PLL1_BW, 8'($random(seed)) & 8'h0F);
      check("PLL0_BW_SEL", {4'h0, bw0}, 8'(mdl[3]));
      check("PLL1_BW_SEL", {4'h0, bw1}, 8'(mdl[4]));
      rd8(A_PLL1_BW);
      check("PLL1_BW", rd, 8'(mdl[4]));
    end
    $display("test bandwidth done");
    // protect lets only the interrupt registers change
    wp_n <= 1'b0;
    wr(A_PLL0_BW, 8'h02);
    wr(A_GPIO_DIR, 8'h5A);
    wr(A_INT_MASK, 8'h01);
    wp_n <= 1'b1;
    rd8(A_PLL0_BW);
    check("PLL0_BW", rd, 8'(mdl[3]));
    rd8(A_INT_MASK);
    check("INT_MASK", rd, 8'(mdl[5]));
    rd8(A_GPIO_DIR);
    check("GPIO_DIR", rd, 8'(mdl[0]));
    $display("test protect done");
    // raise, observe and clear one enabled flag
    wr(A_INT_FLAG, 8'hFF);
    lock <= 2'h1;
    mdl[6] = 1;
    repeat (10) @(posedge clk);
    check("IRQ_OE_N", {7'h00, irq_oe_n}, 8'h00);
    rd8(A_INT_FLAG);
    check("INT_FLAG", rd, 8'(mdl[6]));
    wr(A_INT_FLAG, 8'h01);
    check("IRQ_OE_N", {7'h00, irq_oe_n}, 8'h01);
    $display("test interrupt done");
    // gpio as outputs, as enable inputs, as status outputs
    for (int k = 0; k < 3; k++)
    begin
      wr(A_GPIO_DIR, k == 1 ? 8'h00 : 8'hFF);
      wr(A_GPIO_FUNC, k == 0 ? 8'h00 : 8'hFF);
      wr(A_GPIO_OUT, 8'($random(seed)));
      gdrv <= 8'($random(seed));
      {signal_loss_flag, hold, lock} <= 8'($random(seed));
      repeat (10) @(posedge clk);
      st = {signal_loss_flag, hold, lock};
      e_oen = k == 0 ? 8'(mdl[2]) : (k == 2 ? st : 8'hFF);
      check("GPIO_OE_N", gpio_oe_n, e_oen);
      check("OUT_ENABLE", oe, k == 1 ? gdrv : 8'hFF);
      rd8(A_STATUS);
      check("STATUS", rd, st);
      rd8(A_GPIO_IN);
      check("GPIO_IN", rd, gdrv & e_oen);
    end
    $display("test gpio done");
    // master reset in spi mode: defaults back, no eeprom load
    mrst_n <= 1'b0;
    repeat (10) @(posedge clk);
    mrst_n <= 1'b1;
    mdl_rst();
    for (int c = 0; c < 40; c++)
    begin
      @(posedge clk);
      check("EEPROM_BUSY", {7'h00, busy}, 8'h00);
    end
    check("OUT_ENABLE", oe, 8'hFF);
    rd8(A_PLL0_BW);
    check("PLL0_BW", rd, 8'(mdl[3]));
    $display("test master reset done");
    // two-wire mode: load starts, no eeprom answers, nothing written
    check("SCL_PULLED", {7'h00, saw_scl}, 8'h00);
    mode <= 1'b0;
    repeat (10) @(posedge clk);
    mrst_n <= 1'b0;
    repeat (10) @(posedge clk);
    mrst_n <= 1'b1;
    wait_busy(1'b1, 200);
    wait_busy(1'b0, 60000);
    check("PLL0_BW_SEL", {4'h0, bw0}, 8'(mdl[3]));
    check("SCL_PULLED", {7'h00, saw_scl}, 8'h01);
    check("SER_CLK_OE_N", {7'h00, scl_oe_n}, 8'h01);
    $display("test eeprom done");
    // two-wire host: write, read back, then a foreign address gets no acknowledge
    a7 = {I2C_ADDR_HI, 2'($random(seed))};
    wd = 8'($random(seed)) & 8'h0F;
    i_host.tw_xfer(1'b0, a7, A_PLL1_BW, wd, rd, acks);
    mdl[4] = wd > 8'h0A ? 10 : int'(wd);
    check("TW_WR_ACKS", {5'h00, acks}, 8'h00);
    i_host.tw_xfer(1'b1, a7, A_PLL1_BW, 8'h00, rd, acks);
    check("TW_RD_ACKS", {5'h00, acks}, 8'h00);
    check("TW_READ", rd, 8'(mdl[4]));
    i_host.tw_xfer(1'b0, a7 ^ 7'h40, A_PLL1_BW, 8'h00, rd, acks);
    check("TW_NACKS", {5'h00, acks}, 8'h07);
    check("PLL1_BW_SEL", {4'h0, bw1}, 8'(mdl[4]));
    $display("test two-wire done");
    finish_test();
  end
endmodule : serial_config_port_control_tb_top
`default_nettype wire
